// [hdl/wdvs_top.sv]
// Weld sequence output logic: downslope, valve decode and weld steppers.
`timescale 1ns/10ps
module wdvs_top
  import wdvs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_pin_program,
  input wire logic i_pin_weld_sw,
  input wire logic i_pin_weld_sel,
  input wire logic [2:0] i_sel_valve,
  input wire logic i_sched_run,
  input wire wdvs_sched_type i_sched,
  input wire logic i_weld_go,
  input wire logic i_final_impulse,
  input wire logic i_tick,
  input wire logic [2:0] i_stepper_sel,
  output logic [2:0] o_valve,
  output logic [2:0] o_lamp,
  output logic o_fire,
  output logic [6:0] o_pct,
  output logic o_weld_done,
  output logic [5:0] o_sched_idx,
  output logic o_alarm
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WELD = 2'b01,
    S_SLOPE = 2'b10
  } wdvs_state_type;

  // Pin filters: three flops, a change is taken once the last two agree.
  logic [2:0] pin_in, sync1_q, sync2_q, sync3_q, pin_q;
  assign pin_in = {i_pin_weld_sel, i_pin_weld_sw, i_pin_program};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
          sync3_q[g] <= 1'b0;
          pin_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= pin_in[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
          if (sync2_q[g] == sync3_q[g]) begin
            pin_q[g] <= sync3_q[g];
          end
        end
      end
    end
  endgenerate

  logic prog_s, weld_sw_s, weld_sel_s;
  assign prog_s = pin_q[0];
  assign weld_sw_s = pin_q[1];
  assign weld_sel_s = pin_q[2];

  // Valve drive and lamps; program mode forces all solenoids off.
  logic [2:0] valve_q, lamp_q;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      valve_q <= 3'h0;
      lamp_q <= 3'h0;
    end else if (prog_s) begin
      valve_q <= 3'h0;
      lamp_q <= i_sel_valve;
    end else begin
      valve_q <= i_sched_run ? i_sched.valve : 3'h0;
      lamp_q <= i_sched_run ? i_sched.valve : 3'h0;
    end
  end

  // Weld sequence: weld cycles at full current, then optional downslope.
  wdvs_state_type st_q;
  wdvs_sched_type sch_q;
  logic [6:0] wleft_q, pct_q;
  logic done_q, qual, ramp_start_q;
  logic [6:0] ramp_pct, bottom, slope_cnt;
  logic ramp_busy, ramp_done;

  // A chained successor sets the bottom; otherwise a quarter of the current.
  assign bottom = sch_q.chained ? sch_q.next_pct : (sch_q.pct >> BOTTOM_SHIFT);
  // Out-of-range counts are pulled into the legal window.
  assign slope_cnt = (sch_q.slope_cnt > SLOPE_MAX) ? SLOPE_MAX :
    ((sch_q.slope_cnt < SLOPE_MIN) ? SLOPE_MIN : sch_q.slope_cnt);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= S_IDLE;
      sch_q <= '0;
      wleft_q <= 7'h00;
      done_q <= 1'b0;
      ramp_start_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      ramp_start_q <= 1'b0;
      if (prog_s) begin
        st_q <= S_IDLE; // Program mode aborts firing without counting a weld.
      end else begin
        case (st_q)
          S_IDLE: begin
            if (i_weld_go) begin
              sch_q <= i_sched;
              wleft_q <= i_sched.weld_cyc;
              if (i_sched.weld_cyc == 7'h00) begin
                done_q <= 1'b1;
              end else begin
                st_q <= S_WELD;
              end
            end
          end
          S_WELD: begin
            if (i_tick) begin
              if (wleft_q == 7'h01) begin
                if (sch_q.slope_mode == SLOPE_DOWN && i_final_impulse) begin
                  ramp_start_q <= 1'b1;
                  st_q <= S_SLOPE;
                end else begin
                  done_q <= 1'b1;
                  st_q <= S_IDLE;
                end
              end else begin
                wleft_q <= wleft_q - 7'h01;
              end
            end
          end
          S_SLOPE: begin
            if (ramp_done) begin
              done_q <= 1'b1;
              st_q <= S_IDLE;
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  // Qualification reads the switches live in the done cycle, so their state at the done pulse decides whether the weld counts.
  assign qual = done_q && sch_q.weld_cyc != 7'h00 && sch_q.pct != 7'h00 && weld_sw_s && weld_sel_s;

  // Ramp level is used only once the ramp has loaded, so its stale value never reaches the firing drive.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pct_q <= 7'h00;
    end else begin
      pct_q <= (st_q == S_SLOPE && (ramp_busy || ramp_done)) ? ramp_pct : ((st_q != S_IDLE) ? sch_q.pct : 7'h00);
    end
  end

  wdvs_ramp u_ramp (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_start(ramp_start_q),
    .i_tick(i_tick),
    .i_top_pct(sch_q.pct),
    .i_bottom_pct(bottom),
    .i_count(slope_cnt),
    .o_pct(ramp_pct),
    .o_busy(ramp_busy),
    .o_done(ramp_done)
  );

  // Control registers written by software.
  logic [1:0] mode_q;
  logic alarm_en_q, auto_q;
  logic [5:0] tab_idx_q;
  logic [5:0] last_q [NSTP], last_eff [NSTP];
  logic [CW-1:0] tab_q [NTAB];
  logic [NSTP-1:0] clr;
  logic wr_ctrl, wr_data;

  assign wr_ctrl = i_wr && i_addr == REG_CTRL;
  assign wr_data = i_wr && i_addr == REG_TAB_DATA && tab_idx_q < 6'(NTAB);
  assign clr = (i_wr && i_addr == REG_RESET) ? i_wdata[NSTP-1:0] : '0;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {auto_q, alarm_en_q, mode_q} <= CTRL_RESET;
      tab_idx_q <= 6'h00;
    end else begin
      if (wr_ctrl) begin
        mode_q <= i_wdata[CTRL_MODE_LSB+:2];
        alarm_en_q <= i_wdata[CTRL_ALARM_EN];
        auto_q <= i_wdata[CTRL_AUTO];
      end
      if (i_wr && i_addr == REG_TAB_IDX) begin
        tab_idx_q <= i_wdata[5:0];
      end
    end
  end

  // Step count table; counts above 9999 saturate.
  always_ff @(posedge i_clock) begin
    if (wr_data) begin
      tab_q[tab_idx_q] <= (i_wdata[CW-1:0] > COUNT_MAX) ? COUNT_MAX : i_wdata[CW-1:0];
    end
  end

  // Per stepper state: step, remaining welds, parked flag and alarm.
  logic [5:0] step_q [NSTP];
  logic [CW-1:0] rem_q [NSTP];
  logic [NSTP-1:0] park_q, alarm_q, hit;

  generate
    for (g = 0; g < NSTP; g++) begin : g_stp
      logic [5:0] base, lim;
      assign base = (mode_q == STEP_SINGLE) ? 6'h00 : 6'(g * NSTEP);
      assign lim = (mode_q == STEP_SINGLE) ? LAST_MAX_SINGLE : LAST_MAX_MULTI;
      assign last_eff[g] = (last_q[g] > lim) ? lim : last_q[g];
      assign hit[g] = qual && mode_q != STEP_OFF && !park_q[g] &&
        ((mode_q == STEP_SINGLE) ? (g == 0) : (i_stepper_sel == 3'(g)));

      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          last_q[g] <= LAST_RESET;
        end else if (i_wr && i_addr == REG_LAST0 + 8'(4 * g)) begin
          last_q[g] <= i_wdata[5:0];
        end
      end

      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          step_q[g] <= 6'h00;
          rem_q[g] <= '0;
          park_q[g] <= 1'b0;
        end else if (hit[g]) begin
          if (rem_q[g] <= 14'h0001) begin
            if (step_q[g] >= last_eff[g]) begin
              step_q[g] <= auto_q ? 6'h00 : step_q[g]; // A manual stepper waits on its last step.
              rem_q[g] <= auto_q ? tab_q[base] : '0;
              park_q[g] <= !auto_q;
            end else begin
              step_q[g] <= step_q[g] + 6'h01;
              rem_q[g] <= tab_q[base + step_q[g] + 6'h01];
            end
          end else begin
            rem_q[g] <= rem_q[g] - 14'h0001;
          end
        end else if (clr[g]) begin
          step_q[g] <= 6'h00;
          rem_q[g] <= tab_q[base];
          park_q[g] <= 1'b0;
        end
      end

      // An alarm raised in the clearing cycle survives the clear.
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          alarm_q[g] <= 1'b0;
        end else begin
          alarm_q[g] <= (alarm_q[g] && !clr[g]) ||
            (hit[g] && alarm_en_q && rem_q[g] <= 14'h0001 && step_q[g] >= last_eff[g]);
        end
      end
    end
  endgenerate

  // Schedule the store applies while the selected stepper's step is active.
  logic [5:0] idx_q, sel_idx;
  logic [2:0] sel;
  assign sel = (mode_q == STEP_SINGLE || i_stepper_sel >= 3'(NSTP)) ? 3'h0 : i_stepper_sel;
  assign sel_idx = (mode_q == STEP_SINGLE) ? step_q[0] : 6'(sel * NSTEP) + step_q[sel];

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx_q <= 6'h00;
    end else begin
      idx_q <= (mode_q == STEP_OFF) ? 6'h00 : sel_idx;
    end
  end

  // Read port; unmapped addresses return zero.
  logic [31:0] rdata_q, rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    if (i_addr == REG_CTRL) begin
      rmux = {28'h000_0000, auto_q, alarm_en_q, mode_q};
    end else if (i_addr == REG_TAB_IDX) begin
      rmux = {26'h000_0000, tab_idx_q};
    end else if (i_addr == REG_TAB_DATA) begin
      rmux = (tab_idx_q < 6'(NTAB)) ? {18'h0_0000, tab_q[tab_idx_q]} : 32'h0000_0000;
    end else if (i_addr == REG_STATUS) begin
      rmux = {23'h00_0000, ramp_busy, 3'h0, alarm_q};
    end else begin
      for (int k = 0; k < NSTP; k++) begin
        if (i_addr == REG_LAST0 + 8'(4 * k)) begin
          rmux = {26'h000_0000, last_eff[k]};
        end else if (i_addr == REG_STATE0 + 8'(4 * k)) begin
          rmux = {2'h0, rem_q[k], 9'h000, park_q[k], step_q[k]};
        end
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_rd) begin
      rdata_q <= rmux;
    end
  end

  assign o_rdata = rdata_q;
  assign o_valve = valve_q;
  assign o_lamp = lamp_q;
  assign o_fire = (st_q != S_IDLE);
  assign o_pct = pct_q;
  assign o_weld_done = done_q;
  assign o_sched_idx = idx_q;
  assign o_alarm = |alarm_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence weld_end_s;
    st_q == S_WELD && i_tick && wleft_q == 7'h01 && !prog_s;
  endsequence

  AST_PROG_VALVES_OFF: assert property (prog_s |=> valve_q == 3'h0)
    else $error("valve energized in program mode");
  AST_PROG_LAMPS: assert property (prog_s |=> lamp_q == $past(i_sel_valve))
    else $error("lamps do not show selected valves");
  AST_VALVE_DECODE: assert property ((!prog_s && i_sched_run) |=> valve_q == $past(i_sched.valve))
    else $error("valve decode wrong");
  AST_BOTTOM: assert property (ramp_start_q |->
    bottom == (sch_q.chained ? sch_q.next_pct : {2'h0, sch_q.pct[6:2]})) else $error("bad bottom current");
  AST_SLOPE_FINAL: assert property ((weld_end_s ##0 (i_final_impulse && sch_q.slope_mode == SLOPE_DOWN))
    |=> st_q == S_SLOPE ##0 ramp_start_q) else $error("downslope not started");
  AST_NO_SLOPE: assert property ((weld_end_s ##0 !i_final_impulse) |=> st_q == S_IDLE && done_q)
    else $error("slope before final impulse");
  AST_SLOPE_RANGE: assert property (ramp_start_q |-> slope_cnt >= SLOPE_MIN && slope_cnt <= SLOPE_MAX)
    else $error("slope count out of range");
  AST_NO_COUNT: assert property ((done_q && !weld_sel_s) |=> $stable(rem_q[1]) || $past(clr[1]))
    else $error("count moved without a weld");
  AST_ALARM: assert property ((hit[1] && alarm_en_q && rem_q[1] <= 14'h0001 &&
    step_q[1] >= last_eff[1]) |=> o_alarm) else $error("alarm not raised");
  AST_SINGLE_MODE: assert property ((mode_q == STEP_SINGLE) |-> hit[NSTP-1:1] == '0)
    else $error("extra stepper counted in single mode");
endmodule

// [hdl/wdvs_pkg.sv]
// Shared constants, register map and schedule carrier for the weld downslope, valve and stepper block.
package wdvs_pkg;
  // Stepper geometry: five steppers of ten steps, fifty table entries.
  localparam int NSTP = 5;
  localparam int NSTEP = 10;
  localparam int NTAB = 50;
  localparam int CW = 14;
  localparam logic [CW-1:0] COUNT_MAX = 14'h270F;
  localparam logic [5:0] LAST_MAX_MULTI = 6'h09;
  localparam logic [5:0] LAST_MAX_SINGLE = 6'h31;
  // Slope count limits and the downslope mode code.
  localparam logic [6:0] SLOPE_MIN = 7'h01;
  localparam logic [6:0] SLOPE_MAX = 7'h63;
  localparam logic [1:0] SLOPE_DOWN = 2'h2;
  localparam int BOTTOM_SHIFT = 2;
  // Stepper mode codes.
  localparam logic [1:0] STEP_OFF = 2'h0;
  localparam logic [1:0] STEP_MULTI = 2'h1;
  localparam logic [1:0] STEP_SINGLE = 2'h2;
  // Register byte addresses.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TAB_IDX = 8'h04;
  localparam logic [7:0] REG_TAB_DATA = 8'h08;
  localparam logic [7:0] REG_RESET = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_LAST0 = 8'h20;
  localparam logic [7:0] REG_STATE0 = 8'h40;
  // Field positions of the control, state and status registers.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ALARM_EN = 2;
  localparam int CTRL_AUTO = 3;
  localparam int STATE_REM_LSB = 16;
  localparam int STATUS_BUSY = 8;
  // Reset values.
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [5:0] LAST_RESET = 6'h00;
  // Schedule data presented by the schedule store.
  typedef struct packed {
    logic [6:0] weld_cyc;
    logic [6:0] pct;
    logic [2:0] valve;
    logic [1:0] slope_mode;
    logic [6:0] slope_cnt;
    logic chained;
    logic [6:0] next_pct;
  } wdvs_sched_type;
endpackage

// [hdl/wdvs_ramp.sv]
// Downslope ramp generator: divides the current drop into equal steps and walks it down.
`timescale 1ns/10ps
module wdvs_ramp
  import wdvs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_tick,
  input wire logic [6:0] i_top_pct,
  input wire logic [6:0] i_bottom_pct,
  input wire logic [6:0] i_count,
  output logic [6:0] o_pct,
  output logic o_busy,
  output logic o_done
);
  typedef enum logic [1:0] {
    R_IDLE = 2'b00,
    R_DIV = 2'b01,
    R_RUN = 2'b10
  } wdvs_rstate_type;

  wdvs_rstate_type st_q;
  logic [6:0] pct_q, bot_q, cnt_q, rem_q, quo_q, left_q;
  logic done_q;

  // Step size comes from repeated subtraction; at most 128 clocks, far shorter than a slope cycle.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= R_IDLE;
      pct_q <= 7'h00;
      bot_q <= 7'h00;
      cnt_q <= 7'h01;
      rem_q <= 7'h00;
      quo_q <= 7'h00;
      left_q <= 7'h00;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        R_IDLE: begin
          if (i_start) begin
            pct_q <= i_top_pct;
            bot_q <= i_bottom_pct;
            cnt_q <= i_count;
            left_q <= i_count;
            quo_q <= 7'h00;
            // A bottom above the start gives a zero step and a final jump.
            rem_q <= (i_top_pct > i_bottom_pct) ? i_top_pct - i_bottom_pct : 7'h00;
            st_q <= R_DIV;
          end
        end
        R_DIV: begin
          if (rem_q >= cnt_q) begin
            rem_q <= rem_q - cnt_q;
            quo_q <= quo_q + 7'h01;
          end else begin
            st_q <= R_RUN;
          end
        end
        R_RUN: begin
          if (i_tick) begin
            if (left_q == 7'h01) begin
              pct_q <= bot_q; // Rounding never leaves the ramp short of the bottom.
              done_q <= 1'b1;
              st_q <= R_IDLE;
            end else begin
              pct_q <= pct_q - quo_q;
              left_q <= left_q - 7'h01;
            end
          end
        end
        default: st_q <= R_IDLE;
      endcase
    end
  end

  assign o_pct = pct_q;
  assign o_busy = (st_q != R_IDLE);
  assign o_done = done_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  AST_RAMP_STEP: assert property ((st_q == R_RUN && i_tick && left_q != 7'h01) |=>
    pct_q == $past(pct_q) - quo_q) else $error("ramp step size wrong");
  AST_RAMP_BOTTOM: assert property (done_q |-> pct_q == bot_q)
    else $error("ramp did not end at bottom current");
endmodule

// [tb/wdvs_load_model.sv]
// Far-side model: line-cycle tick source, conduction counter and current level log.
`timescale 1ns/10ps
module wdvs_load_model (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic i_fire,
  input wire logic [6:0] i_pct,
  output logic o_tick,
  output logic [7:0] o_fire_ticks
);
  logic [6:0] tick_cnt_q;
  logic [6:0] last_pct_q;
  logic [6:0] pct_log [0:31];
  int n_pct;
  logic fire_q;

  // The current level is registered one clock behind firing, so the log follows a delayed copy of it.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fire_q <= 1'b0;
    end else begin
      fire_q <= i_fire;
    end
  end

  // Line cycles run free; 120 clocks keeps ticks well above the minimum spacing.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_q <= 7'h00;
      o_tick <= 1'b0;
    end else begin
      tick_cnt_q <= (tick_cnt_q == 7'h77) ? 7'h00 : tick_cnt_q + 7'h01;
      o_tick <= (tick_cnt_q == 7'h77);
    end
  end

  // Count cycles that conduct and log each new current level seen while firing.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fire_ticks <= 8'h00;
      last_pct_q <= 7'h00;
      n_pct <= 0;
    end else if (i_clear) begin
      o_fire_ticks <= 8'h00;
      last_pct_q <= 7'h00;
      n_pct <= 0;
    end else begin
      if (o_tick && i_fire) begin
        o_fire_ticks <= o_fire_ticks + 8'h01;
      end
      // The log is capped so a runaway ramp cannot index past its end.
      if (fire_q && (i_pct != last_pct_q) && (n_pct < 32)) begin
        pct_log[n_pct] <= i_pct;
        n_pct <= n_pct + 1;
        last_pct_q <= i_pct;
      end
    end
  end
endmodule

// [tb/tb_top.sv]
// Self-checking testbench for the weld downslope, valve and stepper block.
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD t=%0t got %0h expected %0h", $time, (a), (b)); end end
module tb_top
  import wdvs_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic i_pin_program = 1'b0;
  logic i_pin_weld_sw = 1'b1;
  logic i_pin_weld_sel = 1'b1;
  logic [2:0] i_sel_valve = 3'h0;
  logic i_sched_run = 1'b0;
  wdvs_sched_type i_sched = '0;
  logic i_weld_go = 1'b0;
  logic i_final_impulse = 1'b0;
  logic i_tick;
  logic [2:0] i_stepper_sel = 3'h0;
  logic [2:0] o_valve;
  logic [2:0] o_lamp;
  logic o_fire;
  logic [6:0] o_pct;
  logic o_weld_done;
  logic [5:0] o_sched_idx;
  logic o_alarm;
  logic clear = 1'b0;
  logic [7:0] fire_ticks;
  logic [31:0] rv;
  int fail_count = 0;
  int num_checks = 0;

  wdvs_top wdvs_top_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_program(i_pin_program),
    .i_pin_weld_sw(i_pin_weld_sw), .i_pin_weld_sel(i_pin_weld_sel), .i_sel_valve(i_sel_valve),
    .i_sched_run(i_sched_run), .i_sched(i_sched), .i_weld_go(i_weld_go),
    .i_final_impulse(i_final_impulse), .i_tick(i_tick), .i_stepper_sel(i_stepper_sel),
    .o_valve(o_valve), .o_lamp(o_lamp), .o_fire(o_fire), .o_pct(o_pct),
    .o_weld_done(o_weld_done), .o_sched_idx(o_sched_idx), .o_alarm(o_alarm));

  wdvs_load_model wdvs_load_model_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clear(clear),
    .i_fire(o_fire), .i_pct(o_pct), .o_tick(i_tick), .o_fire_ticks(fire_ticks));

  // 40 MHz clock.
  initial begin
    forever #12.5 i_clock = ~i_clock;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  // Read data are registered on the strobe edge and held until the next read; they are taken just after it.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // One weld sequence, waiting a bounded time for its done pulse.
  task automatic weld(input logic [6:0] wc, input logic [6:0] p, input logic [1:0] sm, input logic [6:0] sc,
    input logic ch, input logic [6:0] np, input logic fin);
    int i;
    @(posedge i_clock);
    i_sched <= '{weld_cyc: wc, pct: p, valve: 3'h0, slope_mode: sm, slope_cnt: sc, chained: ch, next_pct: np};
    i_final_impulse <= fin;
    i_weld_go <= 1'b1;
    clear <= 1'b1;
    @(posedge i_clock);
    i_weld_go <= 1'b0;
    clear <= 1'b0;
    for (i = 0; i < 30000; i++) begin
      @(posedge i_clock);
      #1;
      if (o_weld_done === 1'b1) break;
    end
    if (i == 30000) begin
      fail_count++;
      $display("BAD t=%0t weld sequence never completed", $time);
      end_sim();
    end
    waitc(3);
  endtask

  // Runs one weld and compares conduction length and the logged current staircase.
  task automatic ramp(input logic [6:0] wc, input logic [6:0] p, input logic [1:0] sm, input logic [6:0] sc,
    input logic ch, input logic [6:0] np, input logic fin, input logic [7:0] ticks, input int n, input int st);
    weld(wc, p, sm, sc, ch, np, fin);
    `CHK(fire_ticks, ticks)
    `CHK(wdvs_load_model_inst.n_pct, n)
    for (int k = 0; k < n; k++) begin
      `CHK(wdvs_load_model_inst.pct_log[k], 7'(int'(p) - k * st))
    end
  endtask

  initial begin
    waitc(12);
    i_rst_n <= 1'b1;
    waitc(8);
    // Register reset values, an unmapped address and the last-step clamp.
    rd(REG_CTRL, rv);
    `CHK(rv, 32'h0000_0000)
    rd(8'hFC, rv);
    `CHK(rv, 32'h0000_0000)
    wr(REG_LAST0 + 8'h10, 32'h0000_003F);
    rd(REG_LAST0 + 8'h10, rv);
    `CHK(rv[5:0], 6'h09)
    // Valve decode in operate mode, then lamps only in program mode.
    i_sched_run <= 1'b1;
    for (int v = 0; v < 8; v++) begin
      i_sched.valve <= 3'(v);
      waitc(3);
      `CHK(o_valve, 3'(v))
    end
    i_pin_program <= 1'b1;
    waitc(8);
    for (int v = 0; v < 8; v++) begin
      i_sel_valve <= 3'(v);
      i_sched.valve <= 3'h7;
      waitc(3);
      `CHK(o_lamp, 3'(v))
      `CHK(o_valve, 3'h0)
    end
    i_pin_program <= 1'b0;
    i_sched_run <= 1'b0;
    waitc(8);
    // Downslope cases: quarter bottom, chained bottom, not final, clamped count, no slope.
    ramp(7'd25, 7'd80, SLOPE_DOWN, 7'd10, 1'b0, 7'd0, 1'b1, 8'd35, 11, 6);
    ramp(7'd20, 7'd75, SLOPE_DOWN, 7'd15, 1'b1, 7'd15, 1'b1, 8'd35, 16, 4);
    ramp(7'd5, 7'd60, SLOPE_DOWN, 7'd10, 1'b0, 7'd0, 1'b0, 8'd5, 1, 0);
    ramp(7'd4, 7'd40, SLOPE_DOWN, 7'd0, 1'b0, 7'd0, 1'b1, 8'd5, 2, 30);
    ramp(7'd3, 7'd50, 2'h0, 7'd10, 1'b0, 7'd0, 1'b1, 8'd3, 1, 0);
    // Stepper 1: counts 2 then 1, last step 1, alarm on, manual return.
    wr(REG_CTRL, 32'h0000_0005);
    wr(REG_TAB_IDX, 32'h0000_000A);
    wr(REG_TAB_DATA, 32'h0000_0002);
    wr(REG_TAB_IDX, 32'h0000_000B);
    wr(REG_TAB_DATA, 32'h0000_0001);
    wr(REG_LAST0 + 8'h04, 32'h0000_0001);
    wr(REG_RESET, 32'h0000_0002);
    i_stepper_sel <= 3'h1;
    rd(REG_STATE0 + 8'h04, rv);
    `CHK(rv, 32'h0002_0000)
    // A zero current weld and a no-weld selection must not count.
    weld(7'd1, 7'd0, 2'h0, 7'd0, 1'b0, 7'd0, 1'b1);
    i_pin_weld_sel <= 1'b0;
    waitc(8);
    weld(7'd1, 7'd50, 2'h0, 7'd0, 1'b0, 7'd0, 1'b1);
    i_pin_weld_sel <= 1'b1;
    waitc(8);
    rd(REG_STATE0 + 8'h04, rv);
    `CHK(rv, 32'h0002_0000)
    weld(7'd1, 7'd50, 2'h0, 7'd0, 1'b0, 7'd0, 1'b1);
    rd(REG_STATE0 + 8'h04, rv);
    `CHK(rv, 32'h0001_0000)
    `CHK(o_sched_idx, 6'h0A)
    weld(7'd1, 7'd50, 2'h0, 7'd0, 1'b0, 7'd0, 1'b1);
    rd(REG_STATE0 + 8'h04, rv);
    `CHK(rv, 32'h0001_0001)
    `CHK(o_sched_idx, 6'h0B)
    `CHK(o_alarm, 1'b0)
    weld(7'd1, 7'd50, 2'h0, 7'd0, 1'b0, 7'd0, 1'b1);
    rd(REG_STATE0 + 8'h04, rv);
    `CHK(rv[6:0], 7'h41)
    `CHK(o_alarm, 1'b1)
    rd(REG_STATUS, rv);
    `CHK(rv[4:0], 5'h02)
    wr(REG_RESET, 32'h0000_0002);
    waitc(2);
    `CHK(o_alarm, 1'b0)
    rd(REG_STATE0 + 8'h04, rv);
    `CHK(rv, 32'h0002_0000)
    // Single stepper over steps 0 and 1 with automatic return; the stepper selector is ignored.
    wr(REG_CTRL, 32'h0000_000A);
    wr(REG_TAB_IDX, 32'h0000_0000);
    wr(REG_TAB_DATA, 32'h0000_0001);
    wr(REG_TAB_IDX, 32'h0000_0001);
    wr(REG_TAB_DATA, 32'h0000_0001);
    wr(REG_LAST0, 32'h0000_0001);
    wr(REG_RESET, 32'h0000_0001);
    i_stepper_sel <= 3'h3;
    weld(7'd1, 7'd50, 2'h0, 7'd0, 1'b0, 7'd0, 1'b1);
    rd(REG_STATE0, rv);
    `CHK(rv, 32'h0001_0001)
    `CHK(o_sched_idx, 6'h01)
    weld(7'd1, 7'd50, 2'h0, 7'd0, 1'b0, 7'd0, 1'b1);
    rd(REG_STATE0, rv);
    `CHK(rv, 32'h0001_0000)
    `CHK(o_alarm, 1'b0)
    end_sim();
  end
endmodule
